// *** inc/t1alm_pkg.sv ***
package t1alm_pkg;
  // timing
  localparam int unsigned CLK_PERIOD_NS  = 10;
  localparam int unsigned AIS_WIN_NS     = 3000000;
  localparam int unsigned AIS_WIN_CYC    = AIS_WIN_NS / CLK_PERIOD_NS;
  localparam int unsigned AUTO_LATCH_NS  = 1000000000;
  localparam int unsigned AUTO_LATCH_CYC = AUTO_LATCH_NS / CLK_PERIOD_NS;
  localparam int          AIS_TMR_W      = 19;
  localparam int          LATCH_TMR_W    = 27;

  // register byte addresses
  localparam logic [7:0] ADDR_TRANSMIT_CONTROL_ONE = 8'h00;
  localparam logic [7:0] ADDR_TRANSMIT_LINK_BYTE   = 8'h04;
  localparam logic [7:0] ADDR_RECEIVE_LINK_BYTE    = 8'h08;
  localparam logic [7:0] ADDR_STATUS_GROUP_EIGHT   = 8'h0c;
  localparam logic [7:0] ADDR_INTERRUPT_MASK       = 8'h10;
  localparam logic [7:0] ADDR_COUNTER_CONFIG       = 8'h14;
  localparam logic [7:0] ADDR_RECEIVE_IO_CONFIG    = 8'h18;
  localparam logic [7:0] ADDR_ALARM_STATE          = 8'h1c;
  localparam logic [7:0] ADDR_ERROR_COUNT          = 8'h20;

  // field positions
  localparam int ST_LINK_BYTE  = 0;
  localparam int ST_FAR_END    = 1;
  localparam int ST_AIS        = 2;
  localparam int ST_W          = 3;
  localparam int CCFG_SELECT   = 0;
  localparam int CCFG_LATCH    = 1;

  // values after reset
  localparam logic             RST_LINK_SOURCE_SELECT = 1'b1;
  localparam logic             RST_COUNTER_UPDATE_SEL = 1'b1;
  localparam logic             RST_RECEIVE_SYNC_DIR   = 1'b1;
  localparam logic [ST_W-1:0]  RST_MASK               = 3'h0;

  // pattern and threshold values
  localparam logic [15:0] ALARM_PATTERN = 16'hffff;
  localparam logic [15:0] COUNT_MAX     = 16'hffff;
  localparam int          HIST_DEPTH    = 16;
  localparam int          HIST_CW       = 5;
  localparam logic [4:0]  FEA_SET_ONES  = 5'h10;
  localparam logic [4:0]  FEA_CLR_MAX   = 5'h0e;
  localparam logic [2:0]  AIS_SET_MAX   = 3'h4;
  localparam logic [2:0]  AIS_ZERO_SAT  = 3'h5;
endpackage : t1alm_pkg

// *** hdl/t1alm_hist.sv ***
`timescale 1ns/10ps
module t1alm_hist #(
  parameter int DEPTH = 16,
  parameter int CW    = 5
) (
  // clock and reset
  input  wire logic          clock,
  input  wire logic          nrst,
  // new pattern
  input  wire logic          shift,
  input  wire logic          bit_in,
  // window summary
  output logic [CW-1:0]      ones,
  output logic               filled
);
  typedef struct packed {
    logic [DEPTH-1:0] hist;
    logic [CW-1:0]    fill;
    logic [CW-1:0]    ones;
  } t1alm_hist_type;

  t1alm_hist_type s_q;
  t1alm_hist_type s_d;

  localparam logic [CW-1:0] FULL = CW'(DEPTH);

  function automatic logic [CW-1:0] t1alm_popcount(input logic [DEPTH-1:0] v);
    logic [CW-1:0] n;
    n = '0;
    for (int i = 0; i < DEPTH; i++) begin
      n = n + CW'(v[i]);
    end
    return n;
  endfunction : t1alm_popcount

  // oldest pattern drops off as each new one enters
  always_comb begin
    s_d = s_q;
    if (shift) begin
      s_d.hist = {s_q.hist[DEPTH-2:0], bit_in};
      if (s_q.fill != FULL) begin
        s_d.fill = s_q.fill + CW'(1);
      end
    end
    s_d.ones = t1alm_popcount(s_d.hist);
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign ones   = s_q.ones;
  assign filled = (s_q.fill == FULL);

  property p_hist_count;
    @(posedge clock) disable iff (!nrst)
      (shift && s_q.fill != FULL) |=> (s_q.fill == $past(s_q.fill) + CW'(1));
  endproperty
  a_hist_count: assert property (p_hist_count) else $error("history fill did not advance");
endmodule : t1alm_hist

// *** hdl/t1alm_monitor.sv ***
`timescale 1ns/10ps
//
// Behaviour
// - link byte register feeds FDL when select zero
// - received link byte refreshes, sets update flag
// - sixteen consecutive all-ones patterns declare alarm
// - fourteen or fewer of sixteen remove alarm
// - error counters saturate, never wrap
// - counter update select zero means manual
// - sync direction resets to one, input
// - four or fewer zeros in 3ms: AIS
// - five or more zeros in 3ms: clear
module t1alm_monitor #(
  parameter int unsigned AIS_WIN_CYCLES    = t1alm_pkg::AIS_WIN_CYC,
  parameter int unsigned AUTO_LATCH_CYCLES = t1alm_pkg::AUTO_LATCH_CYC
) (
  // clock and reset
  input  wire logic        clock,
  input  wire logic        nrst,
  // apb slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             irq,
  // transmit facility data link
  input  wire logic        tx_link_req,
  input  wire logic        ext_link_bit,
  output logic             tx_link_bit,
  // receive facility data link
  input  wire logic        rx_link_valid,
  input  wire logic        rx_link_bit,
  // received line data and errors
  input  wire logic        line_bit_valid,
  input  wire logic        line_bit,
  input  wire logic        err_event,
  // alarms
  output logic             far_end_alarm,
  output logic             ais_alarm,
  // receive sync pin
  input  wire logic        frame_sync,
  input  wire logic        receive_sync_pin_i,
  output logic             receive_sync_pin_o,
  output logic             receive_sync_pin_oe,
  output logic             rx_sync_in
);
  localparam int AW = t1alm_pkg::AIS_TMR_W;
  localparam int LW = t1alm_pkg::LATCH_TMR_W;
  localparam int unsigned AIS_LAST_I   = AIS_WIN_CYCLES - 1;
  localparam int unsigned LATCH_LAST_I = AUTO_LATCH_CYCLES - 1;
  localparam logic [AW-1:0] AIS_LAST   = AIS_LAST_I[AW-1:0];
  localparam logic [LW-1:0] LATCH_LAST = LATCH_LAST_I[LW-1:0];

  typedef struct packed {
    logic                         src_sel;
    logic [7:0]                   tx_byte;
    logic [2:0]                   tx_idx;
    logic                         tx_bit;
    logic [7:0]                   rx_shift;
    logic [2:0]                   rx_cnt;
    logic [7:0]                   rx_byte;
    logic                         half;
    logic [7:0]                   first_byte;
    logic                         pat_stb;
    logic                         pat_ok;
    logic                         eval;
    logic                         fea;
    logic [t1alm_pkg::ST_W-1:0]   status;
    logic [t1alm_pkg::ST_W-1:0]   mask;
    logic [AW-1:0]                ais_tmr;
    logic [2:0]                   zeros;
    logic                         ais;
    logic                         cnt_auto;
    logic [LW-1:0]                latch_tmr;
    logic [15:0]                  err_live;
    logic [15:0]                  err_latch;
    logic                         sync_dir;
    logic                         sync_meta;
    logic                         sync_sync;
    logic                         sync_o;
    logic [31:0]                  rdata;
    logic                         slverr;
  } t1alm_state_type;

  t1alm_state_type st_q;
  t1alm_state_type st_d;

  logic            setup;
  logic            access;
  logic            wr;
  logic            rd_status;
  logic            latch_wr;
  logic            latch_now;
  logic            win_end;
  logic [2:0]      zeros_now;
  logic            byte_done;
  logic [7:0]      byte_now;
  logic [4:0]      hist_ones;
  logic            hist_filled;

  t1alm_hist #(
    .DEPTH (t1alm_pkg::HIST_DEPTH),
    .CW    (t1alm_pkg::HIST_CW)
  ) u_hist (
    .clock  (clock),
    .nrst   (nrst),
    .shift  (st_q.pat_stb),
    .bit_in (st_q.pat_ok),
    .ones   (hist_ones),
    .filled (hist_filled)
  );

  assign setup     = psel && !penable;
  assign access    = psel && penable;
  assign wr        = access && pwrite;
  assign rd_status = access && !pwrite && (paddr == t1alm_pkg::ADDR_STATUS_GROUP_EIGHT);
  assign latch_wr  = wr && (paddr == t1alm_pkg::ADDR_COUNTER_CONFIG) && pwdata[t1alm_pkg::CCFG_LATCH];
  assign win_end   = (st_q.ais_tmr == AIS_LAST);
  assign byte_done = rx_link_valid && (st_q.rx_cnt == 3'h7);
  assign byte_now  = {st_q.rx_shift[6:0], rx_link_bit};
  // manual mode latches only on request; otherwise on the interval timer
  assign latch_now = st_q.cnt_auto ? (st_q.latch_tmr == LATCH_LAST) : latch_wr;
  assign zeros_now = (line_bit_valid && !line_bit && st_q.zeros != t1alm_pkg::AIS_ZERO_SAT) ?
                     st_q.zeros + 3'h1 : st_q.zeros;

  always_comb begin
    st_d         = st_q;
    st_d.pat_stb = 1'b0;
    st_d.eval    = st_q.pat_stb;

    // transmit link bits, msb first
    if (tx_link_req) begin
      if (!st_q.src_sel) begin
        st_d.tx_bit = st_q.tx_byte[3'h7 - st_q.tx_idx];
        st_d.tx_idx = st_q.tx_idx + 3'h1;
      end else begin
        st_d.tx_bit = ext_link_bit;
      end
    end

    // receive link bytes and pairing into patterns
    if (rx_link_valid) begin
      st_d.rx_shift = byte_now;
      st_d.rx_cnt   = st_q.rx_cnt + 3'h1;
    end
    if (byte_done) begin
      st_d.rx_byte = byte_now;
      if (!st_q.half) begin
        st_d.first_byte = byte_now;
        st_d.half       = 1'b1;
      end else begin
        st_d.half    = 1'b0;
        st_d.pat_stb = 1'b1;
        st_d.pat_ok  = ({st_q.first_byte, byte_now} == t1alm_pkg::ALARM_PATTERN);
      end
    end

    // far-end alarm evaluated one cycle after the history has shifted
    if (st_q.eval) begin
      if (hist_filled && hist_ones == t1alm_pkg::FEA_SET_ONES) begin
        st_d.fea = 1'b1;
      end else if (hist_ones <= t1alm_pkg::FEA_CLR_MAX) begin
        st_d.fea = 1'b0;
      end
    end

    // ais window; zero count saturates so a long window cannot wrap it
    if (win_end) begin
      st_d.ais_tmr = '0;
      st_d.zeros   = 3'h0;
      st_d.ais     = (zeros_now <= t1alm_pkg::AIS_SET_MAX);
    end else begin
      st_d.ais_tmr = st_q.ais_tmr + AW'(1);
      st_d.zeros   = zeros_now;
    end

    // error counter
    st_d.latch_tmr = (st_q.latch_tmr == LATCH_LAST) ? '0 : st_q.latch_tmr + LW'(1);
    if (latch_now) begin
      st_d.err_latch = st_q.err_live;
      st_d.err_live  = {15'h0, err_event};
    end else if (err_event && st_q.err_live != t1alm_pkg::COUNT_MAX) begin
      st_d.err_live = st_q.err_live + 16'h1;
    end

    // receive sync pin
    st_d.sync_meta = receive_sync_pin_i;
    st_d.sync_sync = st_q.sync_meta;
    st_d.sync_o    = frame_sync;

    // clear only bits that the read returned; a new event always survives
    if (rd_status) begin
      st_d.status = st_q.status & ~st_q.rdata[t1alm_pkg::ST_W-1:0];
    end
    if (byte_done) begin
      st_d.status[t1alm_pkg::ST_LINK_BYTE] = 1'b1;
    end
    if (st_d.fea != st_q.fea) begin
      st_d.status[t1alm_pkg::ST_FAR_END] = 1'b1;
    end
    if (st_d.ais != st_q.ais) begin
      st_d.status[t1alm_pkg::ST_AIS] = 1'b1;
    end

    // register writes
    if (wr) begin
      if (paddr == t1alm_pkg::ADDR_TRANSMIT_CONTROL_ONE) begin
        st_d.src_sel = pwdata[0];
      end else if (paddr == t1alm_pkg::ADDR_TRANSMIT_LINK_BYTE) begin
        st_d.tx_byte = pwdata[7:0];
        st_d.tx_idx  = 3'h0;
      end else if (paddr == t1alm_pkg::ADDR_INTERRUPT_MASK) begin
        st_d.mask = pwdata[t1alm_pkg::ST_W-1:0];
      end else if (paddr == t1alm_pkg::ADDR_COUNTER_CONFIG) begin
        st_d.cnt_auto = pwdata[t1alm_pkg::CCFG_SELECT];
      end else if (paddr == t1alm_pkg::ADDR_RECEIVE_IO_CONFIG) begin
        st_d.sync_dir = pwdata[0];
      end
    end

    // read data captured in the setup cycle, shown in the access cycle
    if (setup) begin
      st_d.rdata  = 32'h0;
      st_d.slverr = 1'b0;
      if (paddr == t1alm_pkg::ADDR_TRANSMIT_CONTROL_ONE) begin
        st_d.rdata[0] = st_q.src_sel;
      end else if (paddr == t1alm_pkg::ADDR_TRANSMIT_LINK_BYTE) begin
        st_d.rdata[7:0] = st_q.tx_byte;
      end else if (paddr == t1alm_pkg::ADDR_RECEIVE_LINK_BYTE) begin
        st_d.rdata[7:0] = st_q.rx_byte;
      end else if (paddr == t1alm_pkg::ADDR_STATUS_GROUP_EIGHT) begin
        st_d.rdata[t1alm_pkg::ST_W-1:0] = st_q.status;
      end else if (paddr == t1alm_pkg::ADDR_INTERRUPT_MASK) begin
        st_d.rdata[t1alm_pkg::ST_W-1:0] = st_q.mask;
      end else if (paddr == t1alm_pkg::ADDR_COUNTER_CONFIG) begin
        st_d.rdata[t1alm_pkg::CCFG_SELECT] = st_q.cnt_auto;
      end else if (paddr == t1alm_pkg::ADDR_RECEIVE_IO_CONFIG) begin
        st_d.rdata[0] = st_q.sync_dir;
      end else if (paddr == t1alm_pkg::ADDR_ALARM_STATE) begin
        st_d.rdata[1:0] = {st_q.ais, st_q.fea};
      end else if (paddr == t1alm_pkg::ADDR_ERROR_COUNT) begin
        st_d.rdata[15:0] = st_q.err_latch;
      end else begin
        st_d.slverr = 1'b1;
      end
    end
  end

  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      st_q          <= '0;
      st_q.src_sel  <= t1alm_pkg::RST_LINK_SOURCE_SELECT;
      st_q.mask     <= t1alm_pkg::RST_MASK;
      st_q.cnt_auto <= t1alm_pkg::RST_COUNTER_UPDATE_SEL;
      st_q.sync_dir <= t1alm_pkg::RST_RECEIVE_SYNC_DIR;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready              = access;
  assign prdata              = st_q.rdata;
  assign pslverr             = access && st_q.slverr;
  // level output; a handler must read status or clear the mask to drop it
  assign irq                 = |(st_q.status & st_q.mask);
  assign tx_link_bit         = st_q.tx_bit;
  assign far_end_alarm       = st_q.fea;
  assign ais_alarm           = st_q.ais;
  assign receive_sync_pin_o  = st_q.sync_o;
  assign receive_sync_pin_oe = !st_q.sync_dir;
  assign rx_sync_in          = st_q.sync_sync;

  property p_tx_source;
    @(posedge clock) disable iff (!nrst)
      (tx_link_req && !st_q.src_sel) |=> (tx_link_bit == $past(st_q.tx_byte[3'h7 - st_q.tx_idx]));
  endproperty
  a_tx_source: assert property (p_tx_source) else $error("link bit not from link byte");

  property p_link_flag;
    @(posedge clock) disable iff (!nrst)
      byte_done |=> (st_q.status[t1alm_pkg::ST_LINK_BYTE] && st_q.rx_byte == $past(byte_now));
  endproperty
  a_link_flag: assert property (p_link_flag) else $error("link byte refresh not flagged");

  property p_flag_clear;
    @(posedge clock) disable iff (!nrst)
      (rd_status && st_q.rdata[t1alm_pkg::ST_LINK_BYTE] && !byte_done) |=> !st_q.status[t1alm_pkg::ST_LINK_BYTE];
  endproperty
  a_flag_clear: assert property (p_flag_clear) else $error("link byte flag survived its read");

  property p_fea_set;
    @(posedge clock) disable iff (!nrst)
      (st_q.eval && hist_filled && hist_ones == t1alm_pkg::FEA_SET_ONES) |=> far_end_alarm;
  endproperty
  a_fea_set: assert property (p_fea_set) else $error("far-end alarm not declared");

  property p_fea_clr;
    @(posedge clock) disable iff (!nrst)
      (st_q.eval && hist_ones <= t1alm_pkg::FEA_CLR_MAX) |=> !far_end_alarm;
  endproperty
  a_fea_clr: assert property (p_fea_clr) else $error("far-end alarm not removed");

  property p_fea_steady;
    @(posedge clock) disable iff (!nrst)
      !st_q.eval |=> $stable(far_end_alarm);
  endproperty
  a_fea_steady: assert property (p_fea_steady) else $error("far-end alarm moved without pattern");

  property p_saturate;
    @(posedge clock) disable iff (!nrst)
      (st_q.err_live == t1alm_pkg::COUNT_MAX && !latch_now) |=> (st_q.err_live == t1alm_pkg::COUNT_MAX);
  endproperty
  a_saturate: assert property (p_saturate) else $error("error counter wrapped");

  property p_manual_latch;
    @(posedge clock) disable iff (!nrst)
      (!st_q.cnt_auto && latch_wr) |=> (st_q.err_latch == $past(st_q.err_live));
  endproperty
  a_manual_latch: assert property (p_manual_latch) else $error("manual latch not taken");

  property p_sync_dir;
    @(posedge clock) disable iff (!nrst)
      (wr && paddr == t1alm_pkg::ADDR_RECEIVE_IO_CONFIG) |=> (receive_sync_pin_oe == !$past(pwdata[0]));
  endproperty
  a_sync_dir: assert property (p_sync_dir) else $error("sync pin direction wrong");

  property p_ais_set;
    @(posedge clock) disable iff (!nrst)
      (win_end && zeros_now <= t1alm_pkg::AIS_SET_MAX) |=> ais_alarm;
  endproperty
  a_ais_set: assert property (p_ais_set) else $error("ais not declared");

  property p_ais_clr;
    @(posedge clock) disable iff (!nrst)
      (win_end && zeros_now >= t1alm_pkg::AIS_ZERO_SAT) |=> !ais_alarm;
  endproperty
  a_ais_clr: assert property (p_ais_clr) else $error("ais not removed");
endmodule : t1alm_monitor

// *** verif/t1alm_far_end.sv ***
`timescale 1ns/10ps
module t1alm_far_end #(
  parameter int WIN = 40
) (
  // clock and reset
  input  wire logic       clock,
  input  wire logic       nrst,
  // zeros per line window
  input  wire logic [5:0] zeros,
  // facility data link
  output logic            rx_link_valid,
  output logic            rx_link_bit,
  output logic            tx_link_req,
  input  wire logic       tx_link_bit,
  // line bits
  output logic            line_bit_valid,
  output logic            line_bit
);
  logic [5:0] ph_q;

  // periodic, so any WIN-bit window holds the same zero count whatever its phase
  always_ff @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      ph_q <= 6'h00;
    end else begin
      ph_q <= (ph_q == 6'(WIN - 1)) ? 6'h00 : ph_q + 6'h01;
    end
  end
  assign line_bit_valid = nrst;
  assign line_bit       = (ph_q >= zeros);

  initial begin
    rx_link_valid = 1'b0;
    rx_link_bit   = 1'b0;
    tx_link_req   = 1'b0;
  end

  // msb first; released line shows the inverse of the last bit
  task automatic send_byte(input logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      rx_link_valid <= 1'b1;
      rx_link_bit   <= b[i];
      @(posedge clock);
    end
    rx_link_valid <= 1'b0;
    rx_link_bit   <= ~b[0];
  endtask : send_byte

  task automatic pull_byte(output logic [7:0] b);
    for (int i = 7; i >= 0; i--) begin
      tx_link_req <= 1'b1;
      @(posedge clock);
      tx_link_req <= 1'b0;
      @(posedge clock);
      b[i] = tx_link_bit;
    end
  endtask : pull_byte
endmodule : t1alm_far_end

// *** verif/tb.sv ***
`timescale 1ns/10ps
module tb;
  localparam int WIN = 40;
  logic        clock, nrst, psel, penable, pwrite, pready, pslverr, irq;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  logic        tx_link_req, ext_link_bit, tx_link_bit, rx_link_valid, rx_link_bit;
  logic        line_bit_valid, line_bit, err_event, far_end_alarm, ais_alarm;
  logic        frame_sync, ext_sync, sync_o, sync_oe, rx_sync_in, sync_wire;
  logic [5:0]  zeros;
  int          errors, checked, seed;

  assign sync_wire = sync_oe ? sync_o : ext_sync;

  t1alm_monitor #(.AIS_WIN_CYCLES(WIN), .AUTO_LATCH_CYCLES(64)) DUT (
    .clock(clock), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .irq(irq), .tx_link_req(tx_link_req), .ext_link_bit(ext_link_bit), .tx_link_bit(tx_link_bit),
    .rx_link_valid(rx_link_valid), .rx_link_bit(rx_link_bit), .line_bit_valid(line_bit_valid),
    .line_bit(line_bit), .err_event(err_event), .far_end_alarm(far_end_alarm), .ais_alarm(ais_alarm),
    .frame_sync(frame_sync), .receive_sync_pin_i(sync_wire), .receive_sync_pin_o(sync_o),
    .receive_sync_pin_oe(sync_oe), .rx_sync_in(rx_sync_in));

  t1alm_far_end #(.WIN(WIN)) fe (
    .clock(clock), .nrst(nrst), .zeros(zeros), .rx_link_valid(rx_link_valid),
    .rx_link_bit(rx_link_bit), .tx_link_req(tx_link_req), .tx_link_bit(tx_link_bit),
    .line_bit_valid(line_bit_valid), .line_bit(line_bit));

  task automatic wrap_up;
    $display("comparisons %0d, mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask : wrap_up

  task automatic chk_word(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_word

  task automatic chk_bit(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk_bit

  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] wd,
                     output logic [31:0] rd_data, output logic err);
    int n;
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= wd;
    @(posedge clock);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clock);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (pready !== 1'b1) begin
      errors++;
      wrap_up();
    end
    rd_data = prdata;
    err     = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] x;
    logic        e;
    apb(a, 1'b1, d, x, e);
  endtask : wr

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    logic e;
    apb(a, 1'b0, 32'h0, d, e);
  endtask : rd

  function automatic logic fea_exp(int ones, logic prev);
    return (ones == 16) ? 1'b1 : (ones <= 14) ? 1'b0 : prev;
  endfunction : fea_exp

  function automatic logic ais_exp(int z);
    return (z <= 4);
  endfunction : ais_exp

  initial begin
    clock = 1'b0;
    forever #5 clock = ~clock;
  end

  initial begin
    logic [31:0] d;
    logic        e, fea;
    logic [15:0] pat, got, hist;
    logic [7:0]  b;
    int          n;
    int          zt[4];
    {nrst, psel, penable, pwrite, paddr, pwdata} = '0;
    {ext_link_bit, err_event, frame_sync} = '0;
    zt       = '{4, 5, 3, 20};
    ext_sync = 1'b0;
    zeros    = 6'h14;
    errors   = 0;
    checked  = 0;
    seed     = 32'h8128;
    repeat (10) @(posedge clock);
    nrst <= 1'b1;
    @(posedge clock);
    rd(8'h18, d);
    chk_word(d, 32'h1);
    chk_bit(sync_oe, 1'b0);
    rd(8'h14, d);
    chk_word(d, 32'h1);
    apb(8'h24, 1'b0, 32'h0, d, e);
    chk_bit(e, 1'b1);
    // sync pin both ways
    wr(8'h18, 32'h0);
    frame_sync <= 1'b1;
    repeat (4) @(posedge clock);
    chk_bit(sync_oe, 1'b1);
    chk_bit(sync_wire, 1'b1);
    chk_bit(rx_sync_in, 1'b1);
    wr(8'h18, 32'h1);
    ext_sync <= 1'b0;
    repeat (4) @(posedge clock);
    chk_bit(rx_sync_in, 1'b0);
    // transmit link: external source, then register source
    ext_link_bit <= 1'($random(seed));
    fe.pull_byte(b);
    chk_word({24'h0, b}, {24'h0, {8{ext_link_bit}}});
    wr(8'h00, 32'h0);
    pat = 16'($random(seed));
    wr(8'h04, {24'h0, pat[7:0]});
    fe.pull_byte(b);
    chk_word({24'h0, b}, {24'h0, pat[7:0]});
    wr(8'h04, 32'hff);
    repeat (2) begin
      fe.pull_byte(b);
      chk_word({24'h0, b}, 32'hff);
    end
    // receive link: pattern history and interrupt
    wr(8'h10, 32'h1);
    hist = 16'h0;
    fea  = 1'b0;
    for (int i = -1; i < 20; i++) begin
      pat = (i < 0 || i == 16 || i == 18) ? {1'b0, 15'($random(seed))} : 16'hffff;
      for (int j = 1; j >= 0; j--) begin
        fe.send_byte(pat[j*8 +: 8]);
        repeat (2) @(posedge clock);
        chk_bit(irq, 1'b1);
        rd(8'h0c, d);
        chk_word(d & 32'h1, 32'h1);
        chk_bit(irq, 1'b0);
        rd(8'h08, d);
        got[j*8 +: 8] = d[7:0];
      end
      chk_word({16'h0, got}, {16'h0, pat});
      hist = {hist[14:0], pat == 16'hffff};
      fea  = fea_exp($countones(hist), fea);
      chk_bit(far_end_alarm, fea);
    end
    wr(8'h10, 32'h0);
    fe.send_byte(8'h5a);
    repeat (2) @(posedge clock);
    chk_bit(irq, 1'b0);
    // line zero windows at both thresholds
    foreach (zt[k]) begin
      zeros <= 6'(zt[k]);
      repeat (3 * WIN + 5) @(posedge clock);
      chk_bit(ais_alarm, ais_exp(zt[k]));
      rd(8'h1c, d);
      chk_word(d & 32'h2, {30'h0, ais_exp(zt[k]), 1'b0});
    end
    // manual counter latch and saturation
    wr(8'h14, 32'h0);
    wr(8'h14, 32'h2);
    n = 1 + ($random(seed) & 255);
    err_event <= 1'b1;
    repeat (n) @(posedge clock);
    err_event <= 1'b0;
    wr(8'h14, 32'h2);
    rd(8'h20, d);
    chk_word(d, 32'(n));
    err_event <= 1'b1;
    repeat (65600) @(posedge clock);
    err_event <= 1'b0;
    rd(8'h20, d);
    chk_word(d, 32'(n));
    wr(8'h14, 32'h2);
    rd(8'h20, d);
    chk_word(d, 32'hffff);
    rd(8'h14, d);
    chk_word(d, 32'h0);
    wr(8'h14, 32'h1);
    err_event <= 1'b1;
    repeat (200) @(posedge clock);
    rd(8'h20, d);
    err_event <= 1'b0;
    chk_word(d, 32'h40);
    wrap_up();
  end
endmodule : tb
